/* File: verification/spi_host.sv */
/* host model driving the serial register link.
   assumes spi mode 0, sck idle low, 125 ns link period */
`timescale 1ns/1ps
module spi_host (
   output logic      sck,
   output logic      csn,
   output logic      din,
   input  wire logic dout
);
   // ==============================================================
   // frames
   initial begin
      sck = 1'b0;
      csn = 1'b1;
      din = 1'b0;
   end
   // address byte then one data byte; sck stands still between frames
   task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      logic [15:0] s;
      s = {a, d};
      csn = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         din = s[i];
         #62.5 sck = 1'b1;
         if (i < 8) q[i] = dout;
         #62.5 sck = 1'b0;
      end
      #62.5 csn = 1'b1;
      din = ~din; // released line shows no stale value
      #250;
   endtask
   // frame opened with sck held low, to trip the stall guard
   task automatic stall(input int ns);
      csn = 1'b0;
      #(ns) csn = 1'b1;
      #250;
   endtask
endmodule // spi_host

/* File: verification/testbench.sv */
/* self-checking bench for the register bank.
   assumes the host model spi_host on the link side */
`timescale 1ns/1ps
module testbench;
   import accel_regs_pkg::*;
   // ==============================================================
   // signals and design
   logic       clk, rst_n, sck, csn, din, dout, act, flag, emp, full, lvl;
   logic       tilt, flip, move, shake, knock, smp, zok, pop;
   logic [5:0] thr, rdi, wri;
   logic [7:0] rate, irqs, mot, q;
   logic [1:0] grd;
   logic [7:0] ra [8] = '{8'h06,8'h07,8'h08,8'h09,8'h0A,8'h0B,8'h0C,8'h30};
   logic [7:0] re [8] = '{8'h00,8'h00,8'h00,8'h00,8'h01,8'h00,8'h00,8'h00};
   logic [7:0] rc [3] = '{8'h19, 8'h06, 8'h47};
   int         n_fail, compares;
   assign mot[4] = 1'b0;
   spi_host host_u (.sck(sck), .csn(csn), .din(din), .dout(dout));
   accel_control_status_regs #(.STALL_CYCLES(40)) dut_u (
      .clk(clk), .rst_n(rst_n), .sck(sck), .csn(csn), .din(din),
      .dout(dout), .dout_oe(), .tilt_det(tilt), .flip_det(flip),
      .movement_det(move), .shake_det(shake), .double_knock_det(knock),
      .sample_done(smp), .z_sample_ok(zok), .queue_pop(pop),
      .queue_threshold(thr), .sampling_active(act), .output_rate(rate),
      .incline_overturn_enable(mot[0]), .motion_latch_enable(mot[1]),
      .movement_feature_enable(mot[2]), .shake_feature_enable(mot[3]),
      .vertical_direction_select(mot[5]), .unfiltered_flags_select(mot[6]),
      .motion_hold_reset(mot[7]), .low_stall_guard_enable(grd[0]),
      .high_stall_guard_enable(grd[1]), .stall_guard_flag(flag),
      .pending_irqs(irqs), .queue_read_index(rdi),
      .queue_write_index(wri), .queue_empty(emp), .queue_full(full),
      .queue_level_flag(lvl));
   // ==============================================================
   // tasks
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_u.xfer({1'b0, a[6:0]}, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      host_u.xfer({1'b1, a[6:0]}, 8'h00, q);
      chk(q, e);
   endtask
   // w: 0 valid sample, 1 pop, 2 sample done
   task automatic pulse(input int n, input int w);
      repeat (n) begin
         @(posedge clk) #1;
         if (w == 0) zok = 1'b1; else if (w == 1) pop = 1'b1; else smp = 1'b1;
         @(posedge clk) #1;
         {zok, pop, smp} = '0;
      end
      repeat (3) @(posedge clk);
   endtask
   task automatic det(input logic [4:0] v);
      @(posedge clk) #1;
      {knock, shake, move, flip, tilt} = v;
      repeat (4) @(posedge clk);
   endtask
   task automatic end_of_test;
      if (n_fail == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ==============================================================
   // clock, watchdog, tests
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #300000;
      n_fail++;
      end_of_test();
   end
   initial begin
      {tilt, flip, move, shake, knock, smp, zok, pop} = '0;
      thr = 6'h10;
      rst_n = 1'b0;
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      chk({act, grd, flag, irqs[3:0]}, 8'h00);
      for (int i = 0; i < 8; i++) rd(ra[i], re[i]);
      wr(8'h30, 8'hFF);
      wr(8'h0A, 8'hFF);
      rd(8'h0A, 8'h01);
      for (int c = 0; c < 4; c++) begin
         wr(8'h07, 8'(c));
         chk({7'h0, act}, {7'h0, c == 1});
      end
      for (int i = 0; i < 3; i++) begin
         wr(8'h08, rc[i]);
         chk(rate, rc[i]);
      end
      wr(8'h09, 8'hE3);
      repeat (50) @(posedge clk);
      chk(mot, 8'hE3);
      wr(8'h09, 8'h00);
      wr(8'h07, 8'h31);
      chk({6'h0, grd}, 8'h03);
      wr(8'h07, 8'h11);
      host_u.stall(2000);
      chk({7'h0, flag}, 8'h01);
      rd(8'h05, 8'h11);
      chk({7'h0, flag}, 8'h00);
      wr(8'h07, 8'h01);
      wr(8'h06, 8'h08);
      wr(8'h09, 8'h08); // shake without movement on purpose
      det(5'h08);
      chk(irqs, 8'h00);
      wr(8'h09, 8'h0C);
      chk(irqs, 8'h08);
      wr(8'h09, 8'h0D);
      wr(8'h06, 8'h1F);
      det(5'h11);
      chk(irqs, 8'h39);
      det(5'h00);
      chk(irqs, 8'h39);
      wr(8'h14, 8'h00);
      chk(irqs, 8'h00);
      wr(8'h06, 8'h4F);
      det(5'h07);
      chk(irqs, 8'h07);
      det(5'h00);
      chk(irqs, 8'h00);
      wr(8'h06, 8'h80);
      pulse(1, 2);
      chk(irqs, 8'h80);
      pulse(15, 0);
      chk({lvl, full, emp, 5'(wri)}, 8'h0F);
      pulse(1, 0);
      chk({lvl, full, emp, 5'(wri)}, 8'h90);
      pulse(17, 0);
      chk({lvl, full, emp, 5'h0}, 8'hC0);
      rd(8'h0C, 8'h20);
      rd(8'h0A, 8'h06);
      pulse(32, 1);
      chk({2'h0, rdi}, 8'h20);
      chk({lvl, full, emp, 5'h0}, 8'h20);
      end_of_test();
   end
endmodule // testbench

/* File: verilog/accel_control_status_regs.sv */
/*
 * Control and status register bank with its serial register link.
 * Assumes the host runs SPI mode 0 on sck with csn framing, and that the
 * motion and sampling logic sit on clk and drive the detect inputs.
 */
`timescale 1ns/1ps
module accel_control_status_regs
   import accel_regs_pkg::*;
#(
   parameter int STALL_CYCLES = STALL_CYCLES_DFLT
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sck,
   input  wire logic        csn,
   input  wire logic        din,
   output      logic        dout,
   output      logic        dout_oe,
   input  wire logic        tilt_det,
   input  wire logic        flip_det,
   input  wire logic        movement_det,
   input  wire logic        shake_det,
   input  wire logic        double_knock_det,
   input  wire logic        sample_done,
   input  wire logic        z_sample_ok,
   input  wire logic        queue_pop,
   input  wire logic [5:0]  queue_threshold,
   output      logic        sampling_active,
   output      logic [7:0]  output_rate,
   output      logic        incline_overturn_enable,
   output      logic        movement_feature_enable,
   output      logic        shake_feature_enable,
   output      logic        motion_latch_enable,
   output      logic        vertical_direction_select,
   output      logic        unfiltered_flags_select,
   output      logic        motion_hold_reset,
   output      logic        low_stall_guard_enable,
   output      logic        high_stall_guard_enable,
   output      logic        stall_guard_flag,
   output      logic [7:0]  pending_irqs,
   output      logic [5:0]  queue_read_index,
   output      logic [5:0]  queue_write_index,
   output      logic        queue_empty,
   output      logic        queue_full,
   output      logic        queue_level_flag
);
   // ======================================================================
   // state
   typedef struct packed {
      logic        sck_s1;
      logic        sck_s2;
      logic        sck_s3;
      logic        csn_s1;
      logic        csn_s2;
      logic        wt_s1;
      logic        wt_s2;
      logic        wt_s3;
      logic        rc_s1;
      logic        rc_s2;
      logic        rc_s3;
      logic [7:0]  irq_en;
      logic [7:0]  op_state;
      logic [7:0]  rate;
      logic [7:0]  motion;
      logic [7:0]  irq_stat;
      logic        guard_flag;
      logic        abort;
      logic [15:0] stall_cnt;
      logic [5:0]  rd_idx;
      logic [5:0]  wr_idx;
      logic [7:0]  snap_dev;
      logic [7:0]  snap_irq;
      logic [7:0]  snap_qflags;
      logic [7:0]  snap_rd;
      logic [7:0]  snap_wr;
   } core_s;

   typedef struct packed {
      link_e       st;
      logic [2:0]  cnt;
      logic [6:0]  sh;
      logic [6:0]  addr;
      logic        rd;
      logic [7:0]  tx;
   } frame_s;

   typedef struct packed {
      logic        wt;
      logic        rc;
      logic [6:0]  waddr;
      logic [7:0]  wdata;
   } hold_s;

   core_s       c_r;
   core_s       c_nxt;
   frame_s      f_r;
   frame_s      f_nxt;
   hold_s       h_r;
   hold_s       h_nxt;
   logic        dout_r;
   logic        wr_stb;
   logic        rc_stb;
   logic        frame_act;
   logic        active;
   logic        mreset;
   logic        stall;
   logic        frame_rst_n;
   logic [7:0]  set_v;
   logic [7:0]  keep_v;
   logic [5:0]  level;
   logic        q_empty;
   logic        q_full;
   logic        q_thr;
   logic [7:0]  byte_v;
   logic [6:0]  addr_inc;

   // ======================================================================
   // combinational status
   assign wr_stb    = c_r.wt_s2 ^ c_r.wt_s3;
   assign rc_stb    = c_r.rc_s2 ^ c_r.rc_s3;
   assign frame_act = !c_r.csn_s2;
   assign active    = (c_r.op_state[1:0] == ST_ACTIVE);
   assign mreset    = c_r.motion[MC_MRESET];

   // full/empty compare both indexes with the wrap bit
   assign q_empty = (c_r.rd_idx == c_r.wr_idx);
   assign q_full  = (c_r.rd_idx[4:0] == c_r.wr_idx[4:0]) &&
                    (c_r.rd_idx[5] != c_r.wr_idx[5]);
   assign level   = c_r.wr_idx - c_r.rd_idx;
   assign q_thr   = (level >= queue_threshold);

   // detections are gated by the feature and report enables
   always_comb begin
      set_v = 8'h00;
      if (!mreset) begin
         set_v[IE_TILT] = tilt_det && c_r.irq_en[IE_TILT] &&
                          c_r.motion[MC_INCLINE];
         set_v[IE_FLIP] = flip_det && c_r.irq_en[IE_FLIP] &&
                          c_r.motion[MC_INCLINE];
         set_v[IE_MOVE] = movement_det && c_r.irq_en[IE_MOVE] &&
                          c_r.motion[MC_MOVE];
         set_v[IE_SHAKE] = shake_det && c_r.irq_en[IE_SHAKE] &&
                           c_r.motion[MC_SHAKE] &&
                           c_r.motion[MC_MOVE];
         set_v[IE_KNOCK] = double_knock_det && c_r.irq_en[IE_KNOCK] &&
                           c_r.motion[MC_MOVE];
         set_v[IS_SHARED] = set_v[IE_KNOCK];
      end
      set_v[IE_SAMPLE] = sample_done && active &&
                         c_r.irq_en[IE_SAMPLE];
   end

   assign stall = frame_act && (c_r.stall_cnt >= 16'(STALL_CYCLES - 1)) &&
                  ((!c_r.sck_s2 && c_r.op_state[OS_LOW_GUARD]) ||
                   (c_r.sck_s2 && c_r.op_state[OS_HIGH_GUARD]));

   // ======================================================================
   // core next state
   always_comb begin
      c_nxt = c_r;
      keep_v = c_r.irq_stat;
      c_nxt.sck_s1 = sck;
      c_nxt.sck_s2 = c_r.sck_s1;
      c_nxt.sck_s3 = c_r.sck_s2;
      c_nxt.csn_s1 = csn;
      c_nxt.csn_s2 = c_r.csn_s1;
      c_nxt.wt_s1  = h_r.wt;
      c_nxt.wt_s2  = c_r.wt_s1;
      c_nxt.wt_s3  = c_r.wt_s2;
      c_nxt.rc_s1  = h_r.rc;
      c_nxt.rc_s2  = c_r.rc_s1;
      c_nxt.rc_s3  = c_r.rc_s2;
      if (wr_stb) begin
         case (h_r.waddr)
            OFF_IRQ_ENABLE: c_nxt.irq_en   = h_r.wdata & IE_MASK;
            OFF_OP_STATE:   c_nxt.op_state = h_r.wdata & OS_MASK;
            OFF_RATE:       c_nxt.rate     = h_r.wdata;
            OFF_MOTION:     c_nxt.motion   = h_r.wdata & MC_MASK;
            default:        c_nxt.rate     = c_r.rate;
         endcase
      end
      // self-clear drops bits 5:0 once their gated condition is gone; bit 7 is kept
      if (c_r.irq_en[IE_SELFCLR]) begin
         keep_v = c_r.irq_stat & {2'b10, set_v[5:0]};
      end
      if (wr_stb && (h_r.waddr == OFF_IRQ_STATUS)) begin
         keep_v = 8'h00;
      end
      c_nxt.irq_stat = keep_v | set_v;  // set beats a same-cycle clear
      // watchdog: count cycles with sck unchanged inside a frame
      if (!frame_act || (c_r.sck_s2 != c_r.sck_s3)) begin
         c_nxt.stall_cnt = 16'h0000;
      end else if (c_r.stall_cnt != 16'hFFFF) begin
         c_nxt.stall_cnt = c_r.stall_cnt + 16'h0001;
      end
      if (stall) begin
         c_nxt.abort = 1'b1;
      end else if (!frame_act) begin
         c_nxt.abort = 1'b0;
      end
      c_nxt.guard_flag = stall || (c_r.guard_flag && !rc_stb);
      // queue indexes; a full queue drops the new sample
      if (z_sample_ok && active && !q_full) begin
         c_nxt.wr_idx = c_r.wr_idx + 6'h01;
      end
      if (queue_pop && !q_empty) begin
         c_nxt.rd_idx = c_r.rd_idx + 6'h01;
      end
      // snapshot frozen while a frame is open
      if (!frame_act) begin
         c_nxt.snap_dev    = {3'b000, c_r.guard_flag, 2'b00,
                              active ? ST_ACTIVE : ST_IDLE};
         c_nxt.snap_irq    = c_r.irq_stat;
         c_nxt.snap_qflags = {5'b00000, q_thr, q_full, q_empty};
         c_nxt.snap_rd     = {2'b00, c_r.rd_idx};
         c_nxt.snap_wr     = {2'b00, c_r.wr_idx};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         c_r <= '0;
         c_r.csn_s1 <= 1'b1;
         c_r.csn_s2 <= 1'b1;
         c_r.irq_en <= CTRL_RST;
         c_r.op_state <= CTRL_RST;
         c_r.motion <= CTRL_RST;
         c_r.snap_qflags <= QUEUE_FLAGS_RST;
      end else begin
         c_r <= c_nxt;
      end
   end

   // ======================================================================
   // link side: read mux looks at values that are static during a frame
   function automatic logic [7:0] rd_byte(input logic [6:0] a);
      case (a)
         OFF_DEV_STATUS:  rd_byte = c_r.snap_dev;
         OFF_IRQ_ENABLE:  rd_byte = c_r.irq_en;
         OFF_OP_STATE:    rd_byte = c_r.op_state;
         OFF_RATE:        rd_byte = c_r.rate;
         OFF_MOTION:      rd_byte = c_r.motion;
         OFF_QUEUE_FLAGS: rd_byte = c_r.snap_qflags;
         OFF_QUEUE_RD:    rd_byte = c_r.snap_rd;
         OFF_QUEUE_WR:    rd_byte = c_r.snap_wr;
         OFF_IRQ_STATUS:  rd_byte = c_r.snap_irq;
         default:         rd_byte = 8'h00;
      endcase
   endfunction

   // csn high or a watchdog abort returns the link to idle at once
   assign frame_rst_n = rst_n && !csn && !c_r.abort;
   assign byte_v   = {f_r.sh, din};
   assign addr_inc = f_r.addr + 7'h01;

   always_comb begin
      f_nxt = f_r;
      h_nxt = h_r;
      f_nxt.sh  = byte_v[6:0];
      f_nxt.cnt = f_r.cnt + 3'h1;
      f_nxt.tx  = {f_r.tx[6:0], 1'b0};
      case (f_r.st)
         LK_ADDR: begin
            if (f_r.cnt == 3'h7) begin
               f_nxt.addr = byte_v[6:0];
               f_nxt.rd   = byte_v[7];
               f_nxt.st   = LK_DATA;
               if (byte_v[7]) begin
                  f_nxt.tx = rd_byte(byte_v[6:0]);
                  if (byte_v[6:0] == OFF_DEV_STATUS) begin
                     h_nxt.rc = !h_r.rc;
                  end
               end
            end
         end
         LK_DATA: begin
            if (f_r.cnt == 3'h7) begin
               f_nxt.addr = addr_inc;
               if (!f_r.rd) begin
                  h_nxt.waddr = f_r.addr;
                  h_nxt.wdata = byte_v;
                  h_nxt.wt    = !h_r.wt;
               end else begin
                  f_nxt.tx = rd_byte(addr_inc);
                  if (addr_inc == OFF_DEV_STATUS) begin
                     h_nxt.rc = !h_r.rc;
                  end
               end
            end
         end
         default: f_nxt.st = LK_ADDR;
      endcase
   end

   always_ff @(posedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         f_r <= '0;
      end else begin
         f_r <= f_nxt;
      end
   end

   // toggles and write data outlive the frame, so only rst_n clears them
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         h_r <= '0;
      end else begin
         h_r <= h_nxt;
      end
   end

   // launch on the falling edge so the host samples a settled bit
   always_ff @(negedge sck or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         dout_r <= 1'b0;
      end else begin
         dout_r <= f_r.tx[7];
      end
   end

   // ======================================================================
   // outputs
   assign dout    = dout_r;
   assign dout_oe = frame_rst_n && f_r.rd;
   assign sampling_active           = active;
   assign output_rate               = c_r.rate;
   assign incline_overturn_enable   = c_r.motion[MC_INCLINE];
   assign movement_feature_enable   = c_r.motion[MC_MOVE];
   assign shake_feature_enable      = c_r.motion[MC_SHAKE];
   assign motion_latch_enable       = c_r.motion[MC_LATCH];
   assign vertical_direction_select = c_r.motion[MC_VERT];
   assign unfiltered_flags_select   = c_r.motion[MC_UNFILT];
   assign motion_hold_reset         = mreset;
   assign low_stall_guard_enable    = c_r.op_state[OS_LOW_GUARD];
   assign high_stall_guard_enable   = c_r.op_state[OS_HIGH_GUARD];
   assign stall_guard_flag          = c_r.guard_flag;
   assign pending_irqs              = c_r.irq_stat;
   assign queue_read_index          = c_r.rd_idx;
   assign queue_write_index         = c_r.wr_idx;
   assign queue_empty               = q_empty;
   assign queue_full                = q_full;
   assign queue_level_flag          = q_thr;

   // ======================================================================
   // checks
   a_shake_gate: assert property (@(posedge clk) disable iff (!rst_n)
      (!$past(c_r.irq_stat[IE_SHAKE]) && c_r.irq_stat[IE_SHAKE]) |->
      $past(shake_det && c_r.irq_en[IE_SHAKE] && c_r.motion[MC_SHAKE] &&
            c_r.motion[MC_MOVE]))
      else $error("shake pending without all enables");

   a_knock_gate: assert property (@(posedge clk) disable iff (!rst_n)
      (!$past(c_r.irq_stat[IE_KNOCK]) && c_r.irq_stat[IE_KNOCK]) |->
      ($past(c_r.motion[MC_MOVE]) && c_r.irq_stat[IS_SHARED]))
      else $error("double knock pending without movement feature");

   a_sample_flag: assert property (@(posedge clk) disable iff (!rst_n)
      (sample_done && active && c_r.irq_en[IE_SAMPLE]) |=>
      c_r.irq_stat[IE_SAMPLE])
      else $error("sample flag not raised");

   a_self_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (c_r.irq_en[IE_SELFCLR] && !tilt_det) |=>
      !c_r.irq_stat[IE_TILT])
      else $error("tilt bit kept after condition ended");

   a_manual_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (!c_r.irq_en[IE_SELFCLR] && c_r.irq_stat[IE_TILT] &&
       !(wr_stb && h_r.waddr == OFF_IRQ_STATUS)) |=>
      c_r.irq_stat[IE_TILT])
      else $error("pending bit lost without a status write");

   a_wr_step: assert property (@(posedge clk) disable iff (!rst_n)
      (z_sample_ok && active && !q_full) |=>
      (c_r.wr_idx == $past(c_r.wr_idx) + 6'h01))
      else $error("write index did not advance");

   a_flags_excl: assert property (@(posedge clk) disable iff (!rst_n)
      !(q_empty && q_full) and (q_full |-> level == 6'h20))
      else $error("queue empty and full at once");

   a_stall_abort: assert property (@(posedge clk) disable iff (!rst_n)
      stall |=> (c_r.abort && c_r.guard_flag && !frame_rst_n))
      else $error("stall did not abort the link");

   a_snap_frozen: assert property (@(posedge clk) disable iff (!rst_n)
      (frame_act && $past(frame_act)) |-> $stable(c_r.snap_irq) &&
      $stable(c_r.snap_qflags))
      else $error("status snapshot moved during a frame");

   a_idle_code: assert property (@(posedge clk) disable iff (!rst_n)
      (c_r.op_state[1:0] != ST_ACTIVE) |-> !sampling_active ##1
      (!$past(sample_done) || !c_r.irq_stat[IE_SAMPLE] ||
       $past(c_r.irq_stat[IE_SAMPLE]) ||
       $past(wr_stb)))
      else $error("sampling while not in active state");

endmodule // accel_control_status_regs

/* File: verilog/accel_regs_pkg.sv */
/*
 * Constants, field layout and link states for the accelerometer control
 * and status register bank. Assumes a 40 MHz core clock and an SPI-style
 * serial register link driven by the host.
 */
// Functional notes
// - enable register holds one enable per motion source; queue enables live elsewhere
// - shake reported only with its enable, shake and movement features on
// - double-knock reported only with its enable and movement feature on
// - self-clear off: status write clears; on: bit clears when condition ends (code keeps sample bit 7 until a status write)
// - sample enable raises status bit 7 each sample; off after reset
// - state field writable anytime; 00 idle no sampling, 01 active sampling
// - two watchdog enables, serial clock stuck low or high; both off at reset
// - rate byte jointly selects working mode, output rate, oscillator
// - motion bit 0 enables incline/overturn detection; off at reset
// - latch bit holds motion outputs latched, else live
// - vertical select: 0 positive through top, 1 through bottom
// - unfiltered select: 0 debounced flags, 1 raw real-time flags
// - motion reset holds block in reset while set; only software clears it
// - queue empty, full, level flags unregistered, independent of queue enables
// - queue empty reads 1 after reset; queue flags reset to 0x01
// - level flag set when fill at or above threshold; default 16 of 32
// - read and write indexes 6 bits, bits 4:0 address, reset zero
// - bit 5 wrap flag; full and empty from comparing both indexes
// - write index advances per valid sample, valid once Z data acquired
// - reserved queue flag bits read zero
// - enabled watchdog stall sets flag, idles link; status read clears flag
// - status values stay stable for the length of one serial transfer
package accel_regs_pkg;
   // ======================================================================
   // register offsets
   localparam logic [6:0] OFF_DEV_STATUS  = 7'h05;
   localparam logic [6:0] OFF_IRQ_ENABLE  = 7'h06;
   localparam logic [6:0] OFF_OP_STATE    = 7'h07;
   localparam logic [6:0] OFF_RATE        = 7'h08;
   localparam logic [6:0] OFF_MOTION      = 7'h09;
   localparam logic [6:0] OFF_QUEUE_FLAGS = 7'h0A;
   localparam logic [6:0] OFF_QUEUE_RD    = 7'h0B;
   localparam logic [6:0] OFF_QUEUE_WR    = 7'h0C;
   localparam logic [6:0] OFF_IRQ_STATUS  = 7'h14;
   // ======================================================================
   // field positions
   localparam int IE_TILT = 0;
   localparam int IE_FLIP = 1;
   localparam int IE_MOVE = 2;
   localparam int IE_SHAKE = 3;
   localparam int IE_KNOCK = 4;
   localparam int IE_SELFCLR = 6;
   localparam int IE_SAMPLE = 7;
   localparam int IS_SHARED = 5;
   localparam int OS_LOW_GUARD = 4;
   localparam int OS_HIGH_GUARD = 5;
   localparam int MC_INCLINE = 0;
   localparam int MC_LATCH = 1;
   localparam int MC_MOVE = 2;
   localparam int MC_SHAKE = 3;
   localparam int MC_VERT = 5;
   localparam int MC_UNFILT = 6;
   localparam int MC_MRESET = 7;
   // ======================================================================
   // writable masks, reset values, codes
   localparam logic [7:0] IE_MASK = 8'hDF;
   localparam logic [7:0] OS_MASK = 8'h33;
   localparam logic [7:0] MC_MASK = 8'hEF;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] QUEUE_FLAGS_RST = 8'h01;
   localparam logic [1:0] ST_IDLE = 2'h0;
   localparam logic [1:0] ST_ACTIVE = 2'h1;
   localparam int QPTR_W = 6;
   // ======================================================================
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int STALL_TIME_NS = 200000;
   localparam int STALL_CYCLES_DFLT =
      (STALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic {LK_ADDR, LK_DATA} link_e;
endpackage
